// [hdl/pcs_cfg.svh]
// Register offsets, field positions and reset values of the pin configuration block
`ifndef PCS_CFG_SVH
`define PCS_CFG_SVH
`define PCS_ADDR_W 8
`define PCS_OFS_OUT_EN 8'h44
`define PCS_OFS_OUT_VAL 8'h45
`define PCS_OFS_IN_STATE 8'h46
`define PCS_OFS_SIG_CTRL 8'h47
`define PCS_BIT_SIGNAL_IN_PIN 7
`define PCS_BIT_CLOCK_OUT_PIN 6
`define PCS_BIT_HSEL1 5
`define PCS_BIT_HSEL0 4
`define PCS_BIT_TCK 3
`define PCS_BIT_TDI 2
`define PCS_BIT_TDO 1
`define PCS_BIT_TMS 0
`define PCS_SCAN_MASK 8'h0F
`define PCS_FAST_BIT 7
`define PCS_SRC_MSB 3
`define PCS_SRC_LSB 0
`define PCS_RST_BYTE 8'h00
`define PCS_RST_SRC 4'h0
`define PCS_SIG_CTRL_MASK 8'h8F
`endif

// [hdl/pcs_pkg.sv]
// Types of the pin configuration block
package pcs_pkg;
   typedef enum logic [3:0] {
      PCS_SRC_HIZ0 = 4'b0000,
      PCS_SRC_HIZ1 = 4'b0001,
      PCS_SRC_LOW = 4'b0010,
      PCS_SRC_HIGH = 4'b0011,
      PCS_SRC_TX_ENV = 4'b0100,
      PCS_SRC_TX_ACT = 4'b0101,
      PCS_SRC_CONTACT = 4'b0110,
      PCS_SRC_RX_ENV = 4'b0111,
      PCS_SRC_RX_ACT = 4'b1000,
      PCS_SRC_RX_BIT = 4'b1001
   } pcs_src_t;
endpackage

// [hdl/pcs_sig_mux.sv]
// Signal-out pin source selector
`timescale 1ns/1ps
`include "pcs_cfg.svh"
module pcs_sig_mux
   import pcs_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [3:0] signal_output_source,
   input wire logic tx_envelope,
   input wire logic tx_active,
   input wire logic generic_contact_signal,
   input wire logic rx_envelope,
   input wire logic rx_active,
   input wire logic rx_bit,
   output logic signal_out_pin_o,
   output logic signal_out_pin_oe
);
   logic out_next;
   logic oe_next;

   always_comb begin
      out_next = 1'b0;
      oe_next = 1'b1;
      case (signal_output_source)
         PCS_SRC_HIZ0, PCS_SRC_HIZ1: oe_next = 1'b0;
         PCS_SRC_LOW: out_next = 1'b0;
         PCS_SRC_HIGH: out_next = 1'b1;
         PCS_SRC_TX_ENV: out_next = tx_envelope;
         PCS_SRC_TX_ACT: out_next = tx_active;
         PCS_SRC_CONTACT: out_next = generic_contact_signal;
         // Only meaningful for type A at 106 kBd; passed through regardless
         PCS_SRC_RX_ENV: out_next = rx_envelope;
         PCS_SRC_RX_ACT: out_next = rx_active;
         PCS_SRC_RX_BIT: out_next = rx_bit;
         default: oe_next = 1'b0;
      endcase
   end

   // Registered so the pad sees no decode glitches
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         signal_out_pin_o <= 1'b0;
         signal_out_pin_oe <= 1'b0;
      end else if (clk_en) begin
         signal_out_pin_o <= out_next;
         signal_out_pin_oe <= oe_next;
      end
   end

   chk_fixed_high: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && signal_output_source == PCS_SRC_HIGH |=> signal_out_pin_oe && signal_out_pin_o)
      else $error("signal out not driven high");
   chk_hiz_select: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && (signal_output_source <= PCS_SRC_HIZ1 || signal_output_source > PCS_SRC_RX_BIT)
      |=> !signal_out_pin_oe)
      else $error("signal out not 3-state");
   chk_rx_bit_route: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && signal_output_source == PCS_SRC_RX_BIT |=> signal_out_pin_o == $past(rx_bit))
      else $error("rx bit not routed");
   chk_tx_env_route: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && signal_output_source == PCS_SRC_TX_ENV |=> signal_out_pin_oe
      && signal_out_pin_o == $past(tx_envelope))
      else $error("tx envelope not routed");
endmodule

// [hdl/pcs_pin_config.sv]
// Pin configuration register bank and multiplexed pin drivers
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`include "pcs_cfg.svh"
module pcs_pin_config
   import pcs_pkg::*;
#(
   parameter int PIN_COUNT = 8
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [`PCS_ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic boundary_scan_active,
   input wire logic [PIN_COUNT-1:0] scan_pin_o,
   input wire logic [PIN_COUNT-1:0] scan_pin_oe,
   input wire logic clock_out_func,
   input wire logic [PIN_COUNT-1:0] pin_i,
   output logic [PIN_COUNT-1:0] pin_o,
   output logic [PIN_COUNT-1:0] pin_oe,
   input wire logic tx_envelope,
   input wire logic tx_active,
   input wire logic generic_contact_signal,
   input wire logic rx_envelope,
   input wire logic rx_active,
   input wire logic rx_bit,
   output logic signal_out_pin_o,
   output logic signal_out_pin_oe,
   output logic fast_pad_switching
);
   logic [7:0] pin_output_enable_reg;
   logic [7:0] pin_output_value_reg;
   logic [7:0] pin_input_state_reg;
   logic fast_pad_reg;
   logic [3:0] signal_output_source_reg;
   logic [7:0] rdata_next;
   logic [PIN_COUNT-1:0] scan_owned;
   logic [PIN_COUNT-1:0] pin_o_next;
   logic [PIN_COUNT-1:0] pin_oe_next;

   // Register writes
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pin_output_enable_reg <= `PCS_RST_BYTE;
         pin_output_value_reg <= `PCS_RST_BYTE;
         fast_pad_reg <= 1'b0;
         signal_output_source_reg <= `PCS_RST_SRC;
      end else if (clk_en && reg_wr) begin
         if (reg_addr == `PCS_OFS_OUT_EN) begin
            pin_output_enable_reg <= reg_wdata;
         end else if (reg_addr == `PCS_OFS_OUT_VAL) begin
            pin_output_value_reg <= reg_wdata;
         end else if (reg_addr == `PCS_OFS_SIG_CTRL) begin
            fast_pad_reg <= reg_wdata[`PCS_FAST_BIT];
            signal_output_source_reg <= reg_wdata[`PCS_SRC_MSB:`PCS_SRC_LSB];
         end
      end
   end

   // Pins are synchronous inputs; one sample stage feeds the readback
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pin_input_state_reg <= `PCS_RST_BYTE;
      end else if (clk_en) begin
         pin_input_state_reg <= pin_i;
      end
   end

   // Read decode; unmapped addresses and reserved bits read zero
   always_comb begin
      rdata_next = `PCS_RST_BYTE;
      if (reg_addr == `PCS_OFS_OUT_EN) begin
         rdata_next = pin_output_enable_reg;
      end else if (reg_addr == `PCS_OFS_OUT_VAL) begin
         rdata_next = pin_output_value_reg;
      end else if (reg_addr == `PCS_OFS_IN_STATE) begin
         rdata_next = pin_input_state_reg;
      end else if (reg_addr == `PCS_OFS_SIG_CTRL) begin
         rdata_next = {fast_pad_reg, 3'h0, signal_output_source_reg} & `PCS_SIG_CTRL_MASK;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         reg_rdata <= `PCS_RST_BYTE;
      end else if (clk_en) begin
         reg_rdata <= reg_rd ? rdata_next : `PCS_RST_BYTE;
      end
   end

   assign scan_owned = boundary_scan_active ? PIN_COUNT'(`PCS_SCAN_MASK) : '0;

   // Per-pin driver selection
   genvar g;
   generate
      for (g = 0; g < PIN_COUNT; g = g + 1) begin : g_pin
         always_comb begin
            if (scan_owned[g]) begin
               pin_o_next[g] = scan_pin_o[g];
               pin_oe_next[g] = scan_pin_oe[g];
            end else if (pin_output_enable_reg[g]) begin
               pin_o_next[g] = pin_output_value_reg[g];
               pin_oe_next[g] = 1'b1;
            end else if (g == `PCS_BIT_CLOCK_OUT_PIN) begin
               pin_o_next[g] = clock_out_func;
               pin_oe_next[g] = 1'b1;
            end else begin
               pin_o_next[g] = 1'b0;
               pin_oe_next[g] = 1'b0;
            end
         end
      end
   endgenerate

   // Clock-out function passes through a flop, so it is limited to half the clock rate
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pin_o <= '0;
         pin_oe <= '0;
      end else if (clk_en) begin
         pin_o <= pin_o_next;
         pin_oe <= pin_oe_next;
      end
   end

   assign fast_pad_switching = fast_pad_reg;

   pcs_sig_mux u_sig_mux (
      .clk(clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .signal_output_source(signal_output_source_reg),
      .tx_envelope(tx_envelope),
      .tx_active(tx_active),
      .generic_contact_signal(generic_contact_signal),
      .rx_envelope(rx_envelope),
      .rx_active(rx_active),
      .rx_bit(rx_bit),
      .signal_out_pin_o(signal_out_pin_o),
      .signal_out_pin_oe(signal_out_pin_oe)
   );

   chk_enable_drives: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && pin_output_enable_reg[`PCS_BIT_SIGNAL_IN_PIN]
      |=> pin_oe[`PCS_BIT_SIGNAL_IN_PIN]
      && pin_o[`PCS_BIT_SIGNAL_IN_PIN] == $past(pin_output_value_reg[`PCS_BIT_SIGNAL_IN_PIN]))
      else $error("enabled pin not driving its value");
   chk_clock_replaced: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && pin_output_enable_reg[`PCS_BIT_CLOCK_OUT_PIN]
      |=> pin_oe[`PCS_BIT_CLOCK_OUT_PIN]
      && pin_o[`PCS_BIT_CLOCK_OUT_PIN] == $past(pin_output_value_reg[`PCS_BIT_CLOCK_OUT_PIN]))
      else $error("clock function not switched off");
   chk_scan_owns: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && boundary_scan_active
      |=> pin_oe[3:0] == $past(scan_pin_oe[3:0]) && pin_o[3:0] == $past(scan_pin_o[3:0]))
      else $error("scan pins not under scan control");
   chk_input_only: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && !boundary_scan_active && pin_output_enable_reg[`PCS_BIT_HSEL0] == 1'b0
      |=> !pin_oe[`PCS_BIT_HSEL0])
      else $error("unenabled pin drives");
   chk_input_read: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && $past(clk_en) && $past(rst_n) && reg_rd && reg_addr == `PCS_OFS_IN_STATE
      |=> reg_rdata == $past(pin_i, 2))
      else $error("input state readback wrong");
   chk_fast_pad: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && reg_wr && reg_addr == `PCS_OFS_SIG_CTRL
      |=> fast_pad_switching == $past(reg_wdata[`PCS_FAST_BIT]))
      else $error("fast pad bit not stored");

   // Reset leaves every register cleared and every pin released
   chk_reset_regs: assert property (@(posedge clk)
      !rst_n
      |=> pin_output_enable_reg == `PCS_RST_BYTE && pin_output_value_reg == `PCS_RST_BYTE)
      else $error("registers not cleared by reset");
   chk_reset_source: assert property (@(posedge clk)
      !rst_n
      |=> signal_output_source_reg == `PCS_RST_SRC && !fast_pad_reg)
      else $error("control register not cleared by reset");
   chk_reset_pins: assert property (@(posedge clk)
      !rst_n
      |=> pin_oe == '0 && !signal_out_pin_oe)
      else $error("pins driven during reset");
   chk_reset_rdata: assert property (@(posedge clk)
      !rst_n
      |=> reg_rdata == `PCS_RST_BYTE && pin_input_state_reg == `PCS_RST_BYTE)
      else $error("read path not cleared by reset");

   // Stores and holds
   chk_enable_write: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && reg_wr && reg_addr == `PCS_OFS_OUT_EN
      |=> pin_output_enable_reg == $past(reg_wdata))
      else $error("enable register not written");
   chk_value_write: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && reg_wr && reg_addr == `PCS_OFS_OUT_VAL
      |=> pin_output_value_reg == $past(reg_wdata))
      else $error("value register not written");
   chk_source_write: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && reg_wr && reg_addr == `PCS_OFS_SIG_CTRL
      |=> signal_output_source_reg == $past(reg_wdata[`PCS_SRC_MSB:`PCS_SRC_LSB]))
      else $error("source field not written");
   chk_input_ro: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && reg_wr && reg_addr == `PCS_OFS_IN_STATE
      |=> $stable(pin_output_enable_reg) && $stable(pin_output_value_reg))
      else $error("write to input state changed a register");
   chk_enable_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !(clk_en && reg_wr && reg_addr == `PCS_OFS_OUT_EN)
      |=> $stable(pin_output_enable_reg))
      else $error("enable register changed without a write");
   chk_value_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !(clk_en && reg_wr && reg_addr == `PCS_OFS_OUT_VAL)
      |=> $stable(pin_output_value_reg))
      else $error("value register changed without a write");
   chk_control_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !(clk_en && reg_wr && reg_addr == `PCS_OFS_SIG_CTRL)
      |=> $stable(fast_pad_reg) && $stable(signal_output_source_reg))
      else $error("control register changed without a write");

   // A low clock enable must freeze every flop, read data included
   chk_freeze_pins: assert property (@(posedge clk) disable iff (!rst_n)
      !clk_en
      |=> $stable(pin_o) && $stable(pin_oe))
      else $error("pins moved while frozen");
   chk_freeze_input: assert property (@(posedge clk) disable iff (!rst_n)
      !clk_en
      |=> $stable(pin_input_state_reg))
      else $error("input sample moved while frozen");
   chk_freeze_rdata: assert property (@(posedge clk) disable iff (!rst_n)
      !clk_en
      |=> $stable(reg_rdata))
      else $error("read data moved while frozen");
   chk_freeze_signal_out_pin: assert property (@(posedge clk) disable iff (!rst_n)
      !clk_en
      |=> $stable(signal_out_pin_o) && $stable(signal_out_pin_oe))
      else $error("signal out moved while frozen");

   // Read data stands one cycle after the strobe and is zero after any enabled cycle without one
   chk_read_enable: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && reg_rd && reg_addr == `PCS_OFS_OUT_EN
      |=> reg_rdata == $past(pin_output_enable_reg))
      else $error("enable register readback wrong");
   chk_read_value: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && reg_rd && reg_addr == `PCS_OFS_OUT_VAL
      |=> reg_rdata == $past(pin_output_value_reg))
      else $error("value register readback wrong");
   chk_read_control: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && reg_rd && reg_addr == `PCS_OFS_SIG_CTRL
      |=> reg_rdata == {$past(fast_pad_reg), 3'h0, $past(signal_output_source_reg)})
      else $error("control register readback wrong");
   chk_read_unmapped: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && reg_rd && (reg_addr < `PCS_OFS_OUT_EN || reg_addr > `PCS_OFS_SIG_CTRL)
      |=> reg_rdata == `PCS_RST_BYTE)
      else $error("unmapped address reads nonzero");
   chk_read_idle: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && !reg_rd
      |=> reg_rdata == `PCS_RST_BYTE)
      else $error("read data without a read strobe");
   chk_input_sample: assert property (@(posedge clk) disable iff (!rst_n)
      rst_n && clk_en
      |=> pin_input_state_reg == $past(pin_i))
      else $error("input state not sampled");

   // Per-pin ownership: scan logic, software enable, clock function or nobody
   generate
      for (genvar k = 0; k < PIN_COUNT; k = k + 1) begin : g_pin_chk
         chk_pin_driven: assert property (@(posedge clk) disable iff (!rst_n)
            clk_en && pin_output_enable_reg[k] && !scan_owned[k]
            |=> pin_oe[k] && pin_o[k] == $past(pin_output_value_reg[k]))
            else $error("enabled pin not driving its value");
         chk_pin_released: assert property (@(posedge clk) disable iff (!rst_n)
            clk_en && k != `PCS_BIT_CLOCK_OUT_PIN && !pin_output_enable_reg[k] && !scan_owned[k]
            |=> !pin_oe[k])
            else $error("unenabled pin drives");
         chk_pin_scan: assert property (@(posedge clk) disable iff (!rst_n)
            clk_en && scan_owned[k]
            |=> pin_oe[k] == $past(scan_pin_oe[k]) && pin_o[k] == $past(scan_pin_o[k]))
            else $error("scan pin not under scan control");
      end
   endgenerate

   chk_clock_function: assert property (@(posedge clk) disable iff (!rst_n)
      rst_n && clk_en && !pin_output_enable_reg[`PCS_BIT_CLOCK_OUT_PIN]
      |=> pin_oe[`PCS_BIT_CLOCK_OUT_PIN] && pin_o[`PCS_BIT_CLOCK_OUT_PIN] == $past(clock_out_func))
      else $error("clock function not on its pin");
   chk_upper_unscanned: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && boundary_scan_active && pin_output_enable_reg[`PCS_BIT_HSEL1]
      |=> pin_oe[`PCS_BIT_HSEL1] && pin_o[`PCS_BIT_HSEL1] == $past(pin_output_value_reg[5]))
      else $error("scan took a pin it does not own");
   chk_hsel_unscanned: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && boundary_scan_active && !pin_output_enable_reg[`PCS_BIT_HSEL0]
      |=> !pin_oe[`PCS_BIT_HSEL0])
      else $error("scan drives a pin it does not own");
   chk_released_low: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && !boundary_scan_active && !pin_output_enable_reg[`PCS_BIT_TMS]
      |=> !pin_oe[`PCS_BIT_TMS] && !pin_o[`PCS_BIT_TMS])
      else $error("released pin not quiet");
   chk_fast_stable: assert property (@(posedge clk) disable iff (!rst_n)
      !(clk_en && reg_wr && reg_addr == `PCS_OFS_SIG_CTRL)
      |=> $stable(fast_pad_switching))
      else $error("fast pad mode changed without a write");

   // Signal-out selections seen from the register side
   chk_signal_out_pin_low: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && signal_output_source_reg == PCS_SRC_LOW
      |=> signal_out_pin_oe && !signal_out_pin_o)
      else $error("signal out not driven low");
   chk_signal_out_pin_high: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && signal_output_source_reg == PCS_SRC_HIGH
      |=> signal_out_pin_oe && signal_out_pin_o)
      else $error("signal out not driven high");
   chk_signal_out_pin_tx_act: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && signal_output_source_reg == PCS_SRC_TX_ACT
      |=> signal_out_pin_oe && signal_out_pin_o == $past(tx_active))
      else $error("tx active not routed");
   chk_signal_out_pin_contact: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && signal_output_source_reg == PCS_SRC_CONTACT
      |=> signal_out_pin_oe && signal_out_pin_o == $past(generic_contact_signal))
      else $error("contact signal not routed");
   chk_signal_out_pin_rx_env: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && signal_output_source_reg == PCS_SRC_RX_ENV
      |=> signal_out_pin_oe && signal_out_pin_o == $past(rx_envelope))
      else $error("rx envelope not routed");
   chk_signal_out_pin_rx_act: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && signal_output_source_reg == PCS_SRC_RX_ACT
      |=> signal_out_pin_oe && signal_out_pin_o == $past(rx_active))
      else $error("rx active not routed");
   chk_signal_out_pin_reserved: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && signal_output_source_reg > PCS_SRC_RX_BIT
      |=> !signal_out_pin_oe)
      else $error("undefined source drives signal out");
endmodule

// [verif/pcs_board_model.sv]
// Board circuitry seen by the multiplexed pins
`timescale 1ns/1ps
module pcs_board_model (
   input wire logic [7:0] pin_o,
   input wire logic [7:0] pin_oe,
   input wire logic [7:0] board_level,
   output logic [7:0] pin_i
);
   // Board pulls every released pin to its own level, so nothing floats to a lucky value
   assign pin_i = (pin_oe & pin_o) | (~pin_oe & board_level);
endmodule

// [verif/pcs_pin_config_bench.sv]
// Self-checking bench of the pin configuration block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
   err_total++; $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module pcs_pin_config_bench;
   logic clk = 0, rst_n = 0, clk_en = 1, reg_wr = 0, reg_rd = 0, scan_act = 0, ck_func = 0;
   logic [7:0] reg_addr = 0, reg_wdata = 0, scan_o = 0, scan_oe = 0, board_level = 0;
   logic [7:0] reg_rdata, pin_i, pin_o, pin_oe;
   logic [5:0] srcs = 0;
   logic so_o, so_oe, fast;
   int err_total = 0, tests_run = 0, cyc = 0;
   pcs_pin_config #(.PIN_COUNT(8)) dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .boundary_scan_active(scan_act), .scan_pin_o(scan_o),
      .scan_pin_oe(scan_oe), .clock_out_func(ck_func), .pin_i(pin_i), .pin_o(pin_o),
      .pin_oe(pin_oe), .tx_envelope(srcs[5]), .tx_active(srcs[4]),
      .generic_contact_signal(srcs[3]), .rx_envelope(srcs[2]), .rx_active(srcs[1]),
      .rx_bit(srcs[0]), .signal_out_pin_o(so_o), .signal_out_pin_oe(so_oe),
      .fast_pad_switching(fast));
   pcs_board_model board (.pin_o(pin_o), .pin_oe(pin_oe), .board_level(board_level),
      .pin_i(pin_i));
   initial begin
      forever #2 clk = ~clk;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) begin reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; end
      @(posedge clk) reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk) begin reg_addr <= a; reg_rd <= 1'b1; end
      @(posedge clk) reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic t_regs;
      logic [7:0] d;
      wr(8'h44, 8'h5A); rd(8'h44, d); `CHK("out_en", 8'h5A, d)
      wr(8'h45, 8'hC3); rd(8'h45, d); `CHK("out_val", 8'hC3, d)
      wr(8'h47, 8'hFF); rd(8'h47, d); `CHK("sig_ctrl", 8'h8F, d)
      `CHK("fast_on", 1'b1, fast)
      wr(8'h48, 8'hFF); rd(8'h48, d); `CHK("unmapped", 8'h00, d)
      wr(8'h47, 8'h00); settle(1); `CHK("fast_off", 1'b0, fast)
   endtask
   task automatic t_pins;
      wr(8'h44, 8'hFF); wr(8'h45, 8'hA5); settle(3);
      `CHK("oe_all", 8'hFF, pin_oe)
      `CHK("o_all", 8'hA5, pin_o)
      @(posedge clk) ck_func <= 1'b1;
      wr(8'h44, 8'h00); settle(3);
      // Only the clock-out pin keeps driving once every enable is cleared
      `CHK("oe_none", 8'h40, pin_oe)
      `CHK("clk_func", 1'b1, pin_o[6])
   endtask
   task automatic t_scan;
      @(posedge clk) begin scan_act <= 1'b1; scan_oe <= 8'h0A; scan_o <= 8'h05; end
      wr(8'h44, 8'hFF); wr(8'h45, 8'h00); settle(3);
      `CHK("scan_oe", 8'hFA, pin_oe)
      `CHK("scan_o", 8'h05, pin_o)
      @(posedge clk) scan_act <= 1'b0;
   endtask
   task automatic t_input;
      logic [7:0] d;
      @(posedge clk) board_level <= 8'h8B;
      wr(8'h44, 8'h30); wr(8'h45, 8'h10); settle(3);
      rd(8'h46, d); `CHK("in_state", 8'hDB, d)
      wr(8'h46, 8'h00); rd(8'h46, d); `CHK("in_ro", 8'hDB, d)
   endtask
   task automatic t_freeze;
      logic [7:0] d;
      wr(8'h44, 8'h81); wr(8'h45, 8'h80); settle(2);
      // Clock function drops while frozen; the pin must not follow
      @(posedge clk) begin clk_en <= 1'b0; ck_func <= 1'b0; end
      wr(8'h44, 8'h00); settle(2);
      `CHK("frz_oe", 8'hC1, pin_oe)
      `CHK("frz_o", 8'hC0, pin_o)
      @(posedge clk) clk_en <= 1'b1;
      rd(8'h44, d); `CHK("frz_reg", 8'h81, d)
      settle(1); `CHK("rd_clear", 8'h00, reg_rdata)
   endtask
   function automatic logic [1:0] exp_sig(input logic [3:0] s, input logic [5:0] v);
      if (s == 4'h2) return 2'b10;
      if (s == 4'h3) return 2'b11;
      if (s >= 4'h4 && s <= 4'h9) return {1'b1, v[4'h9 - s]};
      return 2'b00;
   endfunction
   task automatic t_src;
      logic [1:0] e;
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 16; i++) begin
            @(posedge clk) srcs <= p ? 6'h29 : 6'h16;
            wr(8'h47, 8'(i)); settle(3);
            e = exp_sig(4'(i), srcs);
            `CHK("sig_oe", e[1], so_oe)
            if (e[1]) `CHK("sig_o", e[0], so_o)
         end
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // The whole sequence needs well under a thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         give_verdict();
      end
   end
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_pins();
      t_scan();
      t_input();
      t_src();
      t_freeze();
      give_verdict();
   end
endmodule
